/* verilog/wdt_map.vh */
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// register byte offsets
`define WDT_OFS_CONTROL 8'h00
`define WDT_OFS_RELOAD 8'h08
`define WDT_OFS_SERVICE 8'h0c

// key field, common to every register
`define WDT_KEY_MSB 31
`define WDT_KEY_LSB 16
`define WDT_KEY_VALUE 16'h5afa

// control register fields
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_IE_BIT 1
`define WDT_CTRL_FLAG_BIT 2

// reload register field
`define WDT_RELOAD_MSB 7
`define WDT_RELOAD_RESET 8'hff

// service register field
`define WDT_SERVICE_MSB 15
`define WDT_SERVICE_VALUE 16'h55aa

// fixed prescaler ratio and counter width
`define WDT_PRESCALE_DIV 128
`define WDT_PRESCALE_BITS 7
`define WDT_COUNT_BITS 9

// count clock source selection
`define WDT_SRC_FAST_OSC 2'h0
`define WDT_SRC_SLOW_OSC 2'h1
`define WDT_SRC_BUS_CLOCK 2'h2
`define WDT_SRC_NONE 2'h3

`endif

/* verilog/wdt_prescaler.v */
`timescale 1ns/1ps
`include "wdt_map.vh"

// divides count clock ticks by a fixed ratio into a one-cycle pulse
module wdt_prescaler #(
  parameter DIV = `WDT_PRESCALE_DIV,
  parameter BITS = `WDT_PRESCALE_BITS
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_clear,
  input wire i_tick,
  output reg o_pulse
);

  localparam [31:0] LAST_FULL = DIV - 1;
  localparam [BITS-1:0] LAST = LAST_FULL[BITS-1:0];

  reg [BITS-1:0] div_reg;

  // count ticks, pulse on the last one of each group
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= {BITS{1'b0}};
      o_pulse <= 1'b0;
    end else if (i_clear) begin
      div_reg <= {BITS{1'b0}};
      o_pulse <= 1'b0;
    end else if (i_tick) begin
      o_pulse <= (div_reg == LAST);
      if (div_reg == LAST) begin
        div_reg <= {BITS{1'b0}};
      end else begin
        div_reg <= div_reg + {{(BITS-1){1'b0}}, 1'b1};
      end
    end else begin
      o_pulse <= 1'b0;
    end
  end

endmodule

/* verilog/wdt_downcounter.v */
`timescale 1ns/1ps
`include "wdt_map.vh"

// down-counter holding the timer constant, flags underflow
module wdt_downcounter #(
  parameter BITS = `WDT_COUNT_BITS
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_load,
  input wire [BITS-1:0] i_load_value,
  input wire i_run,
  input wire i_dec,
  output reg [BITS-1:0] o_value,
  output reg o_underflow
);

  localparam [BITS-1:0] ONE = {{(BITS-1){1'b0}}, 1'b1};

  // load wins over decrement; the last step from one reloads
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_value <= {BITS{1'b0}};
      o_underflow <= 1'b0;
    end else if (i_load) begin
      o_value <= i_load_value;
      o_underflow <= 1'b0;
    end else if (i_run && i_dec) begin
      if (o_value <= ONE) begin
        o_value <= i_load_value;
        o_underflow <= 1'b1;
      end else begin
        o_value <= o_value - ONE;
        o_underflow <= 1'b0;
      end
    end else begin
      o_underflow <= 1'b0;
    end
  end

endmodule

/* verilog/wdt_top.v */
`timescale 1ns/1ps
`include "wdt_map.vh"

// Contract
// - count clock divided by fixed 128 decrements a 9-bit down-counter.
// - smallest start value is one, so shortest timeout is one prescaled period.
// - setting enable bit 0 loads the reload constant and starts counting.
// - reset-mode underflow resets the processor like an external reset.
// - writing 0x55AA to the service field reloads the counter.
// - registers on bus clock, counting on selectable count clock source.
// - interrupt raised only while timeout flag and irq mode enable are set.
// - writes need key 0x5AFA in bits 31:16; key reads zero.
// - flag bit 2 set on interrupt-mode timeout, writing zero clears it.
// - bit 1 low gives reset mode clearing flag; high gives interrupt mode.
// - reload field 7:0 gives constant field plus one; resets to 0xFF.
// - 16-bit service field is write-only and reads zero.
// - timeouts occur whenever enabled and the count clock runs.
// - clock source conflict resolved: source stays selectable.
module wdt_top #(
  parameter ADDR_BITS = 8
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hsel,
  input wire [ADDR_BITS-1:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  input wire [1:0] i_count_clock_select,
  input wire i_internal_fast_osc_tick,
  input wire i_internal_slow_osc_tick,
  output wire o_irq,
  output reg o_wdt_reset
);

  localparam ST_OFF = 2'b01;
  localparam ST_RUN = 2'b10;

  // bus data-phase state
  reg wr_pend_reg;
  reg [ADDR_BITS-1:0] addr_reg;
  reg [31:0] rdata_reg;

  // software-visible state
  reg counter_enable_reg;
  reg counter_enable_next;
  reg irq_mode_enable_reg;
  reg irq_mode_enable_next;
  reg timeout_flag_reg;
  reg timeout_flag_next;
  reg [`WDT_RELOAD_MSB:0] reload_constant_reg;
  reg [`WDT_RELOAD_MSB:0] reload_constant_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;

  // decoded write strobes
  wire [15:0] write_key_field;
  wire [15:0] service_value_field;
  wire key_ok;
  reg hit_control;
  reg hit_reload;
  reg hit_service;
  wire wr_control;
  wire wr_reload;
  wire wr_service;
  wire service_hit;
  wire feed_accept;
  wire flag_clear;
  wire start_load;
  reg count_tick;
  wire prescale_pulse;
  wire underflow;
  wire timeout_event;
  wire flag_set;
  wire reset_request;
  wire counter_load;
  wire running;
  wire [`WDT_COUNT_BITS-1:0] timer_constant;
  wire [31:0] control_image;
  wire [31:0] reload_image;
  wire addr_phase;
  reg [31:0] rdata_next;

  // accept transfers when selected and previous phase completes
  assign addr_phase = i_hsel & i_hready & i_htrans[1];

  // zero-wait slave, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_reg;

  // fields of the write data, meaningful only in a data phase
  assign write_key_field = i_hwdata[`WDT_KEY_MSB:`WDT_KEY_LSB];
  assign service_value_field = i_hwdata[`WDT_SERVICE_MSB:0];

  // data-phase address decode; unmapped offsets hit nothing
  always @* begin
    hit_control = 1'b0;
    hit_reload = 1'b0;
    hit_service = 1'b0;
    case (addr_reg)
      `WDT_OFS_CONTROL: begin
        hit_control = 1'b1;
      end
      `WDT_OFS_RELOAD: begin
        hit_reload = 1'b1;
      end
      `WDT_OFS_SERVICE: begin
        hit_service = 1'b1;
      end
      default: begin
        hit_control = 1'b0;
      end
    endcase
  end

  // key check on every write
  assign key_ok = (write_key_field == `WDT_KEY_VALUE);
  assign wr_control = wr_pend_reg & key_ok & hit_control;
  assign wr_reload = wr_pend_reg & key_ok & hit_reload;
  assign wr_service = wr_pend_reg & key_ok & hit_service;

  // only the exact service value feeds
  assign service_hit = wr_service & (service_value_field == `WDT_SERVICE_VALUE);

  // a feed counts only while the watchdog is enabled
  assign feed_accept = service_hit & counter_enable_reg;

  // writing zero to the flag bit clears it
  assign flag_clear = wr_control & ~i_hwdata[`WDT_CTRL_FLAG_BIT];

  // a rising enable loads the counter
  assign start_load = wr_control & i_hwdata[`WDT_CTRL_EN_BIT] & ~counter_enable_reg;

  // counter load on start or service
  assign counter_load = start_load | feed_accept;

  // timer constant is field plus one
  assign timer_constant = {1'b0, reload_constant_reg} +
    {{(`WDT_COUNT_BITS-1){1'b0}}, 1'b1};

  assign running = state_reg[1];

  // an underflow counts as a timeout only while running
  assign timeout_event = underflow & running;

  // interrupt mode raises the flag, reset mode asks for a chip reset
  assign flag_set = timeout_event & irq_mode_enable_reg;
  assign reset_request = timeout_event & ~irq_mode_enable_reg;

  // pick the count clock source; bus clock ticks every cycle
  always @* begin
    case (i_count_clock_select)
      `WDT_SRC_FAST_OSC: begin
        count_tick = i_internal_fast_osc_tick;
      end
      `WDT_SRC_SLOW_OSC: begin
        count_tick = i_internal_slow_osc_tick;
      end
      `WDT_SRC_BUS_CLOCK: begin
        count_tick = 1'b1;
      end
      default: begin
        count_tick = 1'b0;
      end
    endcase
  end

  // interrupt only when flag and mode bit both set
  assign o_irq = timeout_flag_reg & irq_mode_enable_reg;

  // read images; key, service and reserved bits read zero
  assign control_image = {29'h0000_0000, timeout_flag_next, irq_mode_enable_next,
    counter_enable_next};
  assign reload_image = {{(31-`WDT_RELOAD_MSB){1'b0}}, reload_constant_next};

  // capture address phase of each transfer
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= {ADDR_BITS{1'b0}};
    end else if (i_hready) begin
      wr_pend_reg <= addr_phase & i_hwrite;
      addr_reg <= i_haddr;
    end
  end

  // next values of the software registers
  always @* begin
    counter_enable_next = counter_enable_reg;
    irq_mode_enable_next = irq_mode_enable_reg;
    reload_constant_next = reload_constant_reg;
    timeout_flag_next = timeout_flag_reg;
    if (wr_control) begin
      counter_enable_next = i_hwdata[`WDT_CTRL_EN_BIT];
      irq_mode_enable_next = i_hwdata[`WDT_CTRL_IE_BIT];
    end
    if (wr_reload) begin
      reload_constant_next = i_hwdata[`WDT_RELOAD_MSB:0];
    end
    if (flag_clear) begin
      timeout_flag_next = 1'b0;
    end
    // set wins over clear; reset mode drops the flag
    if (flag_set) begin
      timeout_flag_next = 1'b1;
    end else if (timeout_event) begin
      timeout_flag_next = 1'b0;
    end
  end

  // software register flops
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      counter_enable_reg <= 1'b0;
      irq_mode_enable_reg <= 1'b0;
      timeout_flag_reg <= 1'b0;
      reload_constant_reg <= `WDT_RELOAD_RESET;
    end else begin
      counter_enable_reg <= counter_enable_next;
      irq_mode_enable_reg <= irq_mode_enable_next;
      timeout_flag_reg <= timeout_flag_next;
      reload_constant_reg <= reload_constant_next;
    end
  end

  // run state follows the enable bit
  always @* begin
    case (state_reg)
      ST_OFF: begin
        state_next = counter_enable_next ? ST_RUN : ST_OFF;
      end
      ST_RUN: begin
        state_next = counter_enable_next ? ST_RUN : ST_OFF;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // read mux built from next values so a read after a write sees it
  always @* begin
    rdata_next = 32'h0000_0000;
    if (addr_phase && !i_hwrite) begin
      case (i_haddr)
        `WDT_OFS_CONTROL: begin
          rdata_next = control_image;
        end
        `WDT_OFS_RELOAD: begin
          rdata_next = reload_image;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_hready) begin
      rdata_reg <= rdata_next;
    end
  end

  // reset-mode timeout asks for a full processor reset
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wdt_reset <= 1'b0;
    end else begin
      o_wdt_reset <= reset_request;
    end
  end

  // fixed divider on the selected count clock
  wdt_prescaler #(
    .DIV(`WDT_PRESCALE_DIV),
    .BITS(`WDT_PRESCALE_BITS)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(counter_load | ~running),
    .i_tick(count_tick),
    .o_pulse(prescale_pulse)
  );

  // timer down-counter
  wdt_downcounter #(
    .BITS(`WDT_COUNT_BITS)
  ) u_counter (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_load(counter_load),
    .i_load_value(timer_constant),
    .i_run(running),
    .i_dec(prescale_pulse),
    .o_value(),
    .o_underflow(underflow)
  );

endmodule

/* verification/wdt_chk.sv */
`timescale 1ns/1ps
module wdt_chk #(
  parameter ADDR_BITS = 8
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hsel,
  input wire [ADDR_BITS-1:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_irq,
  input wire o_wdt_reset
);
  reg v_reg;
  reg w_reg;
  reg [ADDR_BITS-1:0] a_reg;
  wire rd_d = v_reg & ~w_reg;
  wire wr_d = v_reg & w_reg;
  // data phase tracking
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      v_reg <= 1'b0;
      w_reg <= 1'b0;
      a_reg <= {ADDR_BITS{1'b0}};
    end else begin
      v_reg <= i_hsel & i_hready & i_htrans[1];
      w_reg <= i_hwrite;
      a_reg <= i_haddr;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ready_const_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready and okay");
  key_zero_a: assert property (o_hrdata[31:16] == 16'h0000)
    else $error("key field reads nonzero");
  svc_zero_a: assert property (rd_d && a_reg == 8'h0c |-> o_hrdata == 32'h0000_0000)
    else $error("service register reads nonzero");
  reload_width_a: assert property (rd_d && a_reg == 8'h08 |-> o_hrdata[15:8] == 8'h00)
    else $error("reload reserved bits nonzero");
  ctrl_width_a: assert property (rd_d && a_reg == 8'h00 |-> o_hrdata[15:3] == 13'h0)
    else $error("control reserved bits nonzero");
  pulse_one_a: assert property (o_wdt_reset |=> !o_wdt_reset)
    else $error("reset request longer than one cycle");
  rst_mode_a: assert property (o_wdt_reset |-> !o_irq)
    else $error("interrupt with reset request");
  irq_off_a: assert property (wr_d && a_reg == 8'h00 && i_hwdata[31:16] == 16'h5afa
    && !i_hwdata[1] |=> !o_irq) else $error("interrupt without irq mode");
  irq_hold_a: assert property ($fell(o_irq) |-> $past(wr_d))
    else $error("interrupt dropped without write");
endmodule
bind wdt_top wdt_chk #(.ADDR_BITS(ADDR_BITS)) chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
  .o_hreadyout(o_hreadyout), .o_irq(o_irq), .o_wdt_reset(o_wdt_reset));

/* verification/wdt_cpu_model.sv */
`timescale 1ns/1ps
module wdt_cpu_model (
  input wire i_clk,
  input wire [31:0] i_hrdata,
  output reg o_hsel = 1'b0,
  output reg [7:0] o_haddr = 8'h00,
  output reg [1:0] o_htrans = 2'h0,
  output reg o_hwrite = 1'b0,
  output reg [31:0] o_hwdata = 32'h0000_0000
);
  // one single transfer: address phase, then data phase
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge i_clk);
      #1;
      o_hsel = 1'b1;
      o_htrans = 2'h2;
      o_hwrite = w;
      o_haddr = a;
      @(posedge i_clk);
      #1;
      o_hsel = 1'b0;
      o_htrans = 2'h0;
      o_hwdata = d;
      @(posedge i_clk);
      q = i_hrdata;
      #1;
      o_hwdata = ~d;
    end
  endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  reg i_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg [1:0] sel = 2'h2;
  wire hsel, hwrite, irq, wrst, hready;
  integer seed = 25684;
  wire [7:0] haddr;
  wire [1:0] htrans;
  wire [31:0] hwdata, hrdata;
  integer cyc = 0, miscompares = 0, compares = 0, i;
  reg [31:0] q, v;
  // clock
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  wdt_cpu_model cpu (.i_clk(i_clk), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));
  wdt_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
    .i_count_clock_select(sel), .i_internal_fast_osc_tick(cyc[0]),
    .i_internal_slow_osc_tick(cyc[1:0] == 2'h3), .o_irq(irq), .o_wdt_reset(wrst));
  // cycle count, oscillator ticks and hang limit
  always @(posedge i_clk) begin
    #1;
    cyc = cyc + 1;
    if (cyc > 20000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      cpu.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
    end
  endtask
  // cycles from enable to timeout for m cycles per tick
  function integer tmo(input integer m, input [7:0] t);
    tmo = 128 * m * (t + 1);
  endfunction
  task run(input [1:0] s, input [7:0] t, input ie, input integer m);
    integer n, lo;
    begin
      sel = s;
      lo = tmo(m, t);
      wr(8'h08, {16'h5afa, 8'h00, t});
      wr(8'h00, {16'h5afa, 14'h0, ie, 1'b1});
      n = 0;
      while ((ie ? irq : wrst) !== 1'b1 && n < 5000) begin
        @(posedge i_clk);
        #1;
        n = n + 1;
      end
      chk(32'(n >= lo - m && n <= lo + 4 * m), 32'h1);
      rd(8'h00, {29'h0, ie, ie, 1'b1});
      wr(8'h00, {16'h5afa, 16'h0000});
      $display("timeout test done, source %0d", s);
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    v = $urandom(seed);
    repeat (2) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0000_00ff);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h0);
    v = $urandom;
    wr(8'h08, {16'h5afa, v[15:0]});
    rd(8'h08, {24'h0, v[7:0]});
    wr(8'h08, {v[31:16] | 16'h0001, ~v[15:0]});
    rd(8'h08, {24'h0, v[7:0]});
    wr(8'h0c, {16'h5afa, 16'h55aa});
    rd(8'h0c, 32'h0);
    $display("register test done");
    for (i = 0; i < 3; i = i + 1)
      run(i[1:0], 8'($urandom % 3), 1'b1, (i == 2) ? 1 : 2 << i);
    run(2'h2, 8'h00, 1'b0, 1);
    wr(8'h08, {16'h5afa, 16'h0001});
    wr(8'h00, {16'h5afa, 16'h0003});
    for (i = 0; i < 3; i = i + 1) begin
      repeat (200) @(posedge i_clk);
      wr(8'h0c, {16'h5afa, 16'h55aa});
    end
    chk(irq, 32'h0);
    v = $urandom;
    repeat (200) @(posedge i_clk);
    wr(8'h0c, {16'h5afa, v[15:0] | 16'h0001});
    repeat (70) @(posedge i_clk);
    #1;
    chk(irq, 32'h1);
    wr(8'h0c, {16'h5afa, 16'h55aa});
    wr(8'h00, {16'h5afa, 16'h0003});
    rd(8'h00, 32'h3);
    chk(irq, 32'h0);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h3);
    sel = 2'h3;
    repeat (600) @(posedge i_clk);
    #1;
    chk(irq, 32'h0);
    $display("service test done");
    give_verdict;
  end
endmodule
